// [verilog/pbc_pkg.sv]
// Shared types and constants of the bridge claim and parity block
package pbc_pkg;
	// --------------------------------------------------------------
	// Timing and reset values
	// --------------------------------------------------------------
	localparam int PBC_CLK_HZ = 40000000;
	localparam int PBC_PULSE_RESET_CLOCKS = 20;
	localparam logic [15:0] PBC_CMD_RESET = 16'h0000;
	localparam int PBC_CMD_PERR_BIT = 6;
	localparam int PBC_CMD_SERR_BIT = 8;
	localparam int PBC_DEVNUM_LSB = 11;
	localparam int PBC_IDSEL_LSB = 16;
	localparam int PBC_IDSEL_COUNT = 16;
	localparam logic [1:0] PBC_TYPE0 = 2'h0;
	localparam logic [1:0] PBC_TYPE1 = 2'h1;

	// --------------------------------------------------------------
	// Claim decision for one observed address phase
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		PBC_DEC_NONE,
		PBC_DEC_LOCAL,
		PBC_DEC_FAR
	} pbc_dec_t;

	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe;
		logic write;
		logic cfg_type1;
	} pbc_req_t;

	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe;
	} pbc_word_t;
endpackage

// [verilog/pbc_buf2.sv]
// Two-entry valid/ready buffer for forwarded words
`timescale 1ns/10ps
`default_nettype none
module pbc_buf2 #(
	parameter int WIDTH = 36
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_q [2];
	logic wp_q;
	logic rp_q;
	logic [1:0] cnt_q;
	logic push;
	logic pop;

	// ------------------------------------------------------------
	// Handshakes
	// ------------------------------------------------------------
	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rp_q];

	// Storage
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				wp_q <= ~wp_q;
			end
			if (pop) begin
				rp_q <= ~rp_q;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 2'h1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [verilog/pbc_sync.sv]
// Two-flop synchroniser for a group of bits
`timescale 1ns/10ps
`default_nettype none
module pbc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// First stage is read only by the second
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// [verilog/pbc_bridge.sv]
// Claim, parity and error logic of a two-port bus bridge
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Upstream local cycles are never claimed
// - Up-to-down cycle: claim, post or retry
// - Down-to-up cycle: claim, post or retry
// - Upstream cycle to nowhere stays unclaimed
// - Downstream local or nowhere stays unclaimed
// - Master abort drops frame, then irdy
// - Check parity on addresses and writes
// - Even parity, par one clock later
// - Read parity covers data and byte enables
// - Address parity error: one-clock serr pulse, two clocks later
// - Serr needs command bits 6 and 8
// - Write parity error: perr two clocks later
// - Target reports writes on perr; master read errors abort, no perr
// - Address parity error blocks the claim
// - Master read parity error causes abort
// - Type 1 to secondary becomes Type 0
// - Device number bits 15:11 select idsel
// - Register bits support RO RW W1C W1S W1R
module pbc_bridge
	import pbc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic up_clk,
	input wire logic up_frame_n,
	input wire logic up_irdy_n,
	input wire logic [31:0] up_ad_in,
	input wire logic [3:0] up_cbe_n_in,
	input wire logic up_parity_in,
	input wire logic up_other_devsel_n,
	input wire logic up_hit_down,
	input wire logic up_hit_up,
	input wire logic up_write,
	input wire logic up_cfg_type1,
	input wire logic down_frame_n,
	input wire logic down_irdy_n,
	input wire logic [31:0] down_ad_in,
	input wire logic [3:0] down_cbe_n_in,
	input wire logic down_parity_in,
	input wire logic down_hit_up,
	input wire logic down_hit_down,
	input wire logic down_write,
	input wire logic down_target_devsel_n,
	input wire logic [31:0] read_data,
	input wire logic read_valid,
	input wire logic post_room,
	input wire logic cmd_wr,
	input wire logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_w1c,
	input wire logic [15:0] cmd_w1s,
	input wire logic [15:0] cmd_w1r,
	input wire logic [15:0] status_set,
	output logic [15:0] cmd_rdata,
	output logic [15:0] status_rdata,
	output logic [15:0] pulse_rdata,
	output logic up_devsel_n,
	output logic up_devsel_oe,
	output logic up_stop_n,
	output logic up_trdy_n,
	output logic up_parity,
	output logic up_parity_oe,
	output logic up_system_error_n,
	output logic up_system_error_oe,
	output logic up_parity_error_n,
	output logic up_parity_error_oe,
	output logic down_devsel_n,
	output logic down_devsel_oe,
	output logic down_stop_n,
	output logic down_parity,
	output logic down_parity_oe,
	output logic down_frame_out_n,
	output logic down_irdy_out_n,
	output logic down_master_oe,
	output logic down_master_abort,
	output logic [31:0] down_ad_out,
	output logic down_ad_oe,
	output logic fwd_valid,
	input wire logic fwd_ready,
	output pbc_word_t fwd_word
);
	// ------------------------------------------------------------
	// Synchronised inputs
	// ------------------------------------------------------------
	localparam int UPW = 1 + 1 + 32 + 4 + 1 + 1;
	localparam int DNW = 1 + 1 + 32 + 4 + 1 + 1;
	logic [UPW-1:0] up_s;
	logic [DNW-1:0] dn_s;
	logic up_clk_s;
	logic up_clk_d1_q;
	logic up_edge;
	logic uf_n, ui_n, up_pin, up_odev_n;
	logic [31:0] uad;
	logic [3:0] ucbe;
	logic df_n, di_n, dn_pin, dn_tdev_n;
	logic [31:0] dad;
	logic [3:0] dcbe;

	pbc_sync #(.WIDTH(UPW)) u_sync_up (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in({up_frame_n, up_irdy_n, up_ad_in, up_cbe_n_in, up_parity_in, up_other_devsel_n}),
		.sync_out(up_s)
	);
	pbc_sync #(.WIDTH(DNW)) u_sync_dn (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in({down_frame_n, down_irdy_n, down_ad_in, down_cbe_n_in, down_parity_in, down_target_devsel_n}),
		.sync_out(dn_s)
	);
	pbc_sync #(.WIDTH(1)) u_sync_clk (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(up_clk),
		.sync_out(up_clk_s)
	);
	assign {uf_n, ui_n, uad, ucbe, up_pin, up_odev_n} = up_s;
	assign {df_n, di_n, dad, dcbe, dn_pin, dn_tdev_n} = dn_s;

	// Rising edge of the bus clock
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			up_clk_d1_q <= 1'b0;
		end else begin
			up_clk_d1_q <= up_clk_s;
		end
	end
	assign up_edge = up_clk_s && !up_clk_d1_q;

	// ------------------------------------------------------------
	// Command register with its access kinds
	// ------------------------------------------------------------
	logic [15:0] cmd_q;
	logic [15:0] stat_q;
	logic [15:0] pulse_q;
	logic [4:0] pulse_cnt_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmd_q <= PBC_CMD_RESET;
		end else if (cmd_wr) begin
			cmd_q <= (cmd_wdata | cmd_w1s);
		end else begin
			cmd_q <= cmd_q | cmd_w1s;
		end
	end

	// Sticky status: hardware set wins over clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stat_q <= 16'h0000;
		end else begin
			stat_q <= (stat_q & ~cmd_w1c) | status_set;
		end
	end

	// Write one to reset, held for a fixed count
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pulse_q <= 16'h0000;
			pulse_cnt_q <= 5'h00;
		end else if (cmd_w1r != 16'h0000) begin
			pulse_q <= pulse_q | cmd_w1r;
			pulse_cnt_q <= 5'(PBC_PULSE_RESET_CLOCKS);
		end else if (pulse_cnt_q != 5'h00) begin
			pulse_cnt_q <= pulse_cnt_q - 5'h01;
		end else begin
			pulse_q <= 16'h0000;
		end
	end
	assign cmd_rdata = cmd_q;
	assign status_rdata = stat_q;
	assign pulse_rdata = pulse_q;

	// ------------------------------------------------------------
	// Upstream address phase, parity and claim
	// ------------------------------------------------------------
	logic uf_prev_q;
	logic addr_ph;
	logic addr_q, wdata_q, rdata_q;
	logic exp_par_q;
	logic in_cyc_q;
	logic cyc_write_q;
	logic claim_q;
	logic [1:0] serr_sr_q;
	logic [1:0] perr_sr_q;
	logic [31:0] addr_lat_q;
	logic [3:0] cbe_lat_q;
	logic buf_in_ready;
	logic can_post;

	assign addr_ph = up_edge && !uf_n && uf_prev_q;
	assign can_post = post_room && buf_in_ready; // Room in core and in buffer

	// Phase tracker: which phase the incoming par belongs to
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			uf_prev_q <= 1'b1;
			addr_q <= 1'b0;
			wdata_q <= 1'b0;
			in_cyc_q <= 1'b0;
			cyc_write_q <= 1'b0;
			exp_par_q <= 1'b0;
			addr_lat_q <= 32'h0000_0000;
			cbe_lat_q <= 4'h0;
		end else if (up_edge) begin
			uf_prev_q <= uf_n;
			addr_q <= addr_ph;
			// Only a completed data phase is checked by us as target
			wdata_q <= in_cyc_q && cyc_write_q && !ui_n && !up_trdy_n;
			exp_par_q <= ^{uad, ucbe};
			if (addr_ph) begin
				in_cyc_q <= 1'b1;
				cyc_write_q <= up_write;
				addr_lat_q <= uad;
				cbe_lat_q <= ucbe;
			end else if (uf_n && ui_n) begin
				in_cyc_q <= 1'b0;
			end
		end
	end

	// Claim: far target only, no other claimant, clean address
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			claim_q <= 1'b0;
		end else if (up_edge) begin
			if (addr_q) begin
				claim_q <= up_hit_down && !up_hit_up && up_odev_n
					&& (exp_par_q == up_pin);
			end else if (uf_n && ui_n) begin
				claim_q <= 1'b0;
			end
		end
	end
	assign up_devsel_n = !claim_q;
	assign up_devsel_oe = claim_q;
	assign up_stop_n = !(claim_q && (cyc_write_q ? !can_post : !read_valid));
	assign up_trdy_n = !(claim_q && (cyc_write_q ? can_post : read_valid));

	// Error pulses two clocks after the faulty phase
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			serr_sr_q <= 2'h0;
			perr_sr_q <= 2'h0;
		end else if (up_edge) begin
			serr_sr_q <= {serr_sr_q[0], addr_q && (exp_par_q != up_pin)};
			perr_sr_q <= {perr_sr_q[0], wdata_q && (exp_par_q != up_pin)};
		end
	end
	assign up_system_error_oe = serr_sr_q[1] && cmd_q[PBC_CMD_PERR_BIT] && cmd_q[PBC_CMD_SERR_BIT];
	assign up_system_error_n = !up_system_error_oe;
	assign up_parity_error_oe = perr_sr_q[1] && cmd_q[PBC_CMD_PERR_BIT];
	assign up_parity_error_n = !up_parity_error_oe;

	// Read parity driven one bus clock after the data
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			up_parity <= 1'b0;
			up_parity_oe <= 1'b0;
		end else if (up_edge) begin
			up_parity <= ^{read_data, ucbe};
			up_parity_oe <= claim_q && !cyc_write_q && read_valid;
		end
	end

	// ------------------------------------------------------------
	// Downstream claim, parity check and idsel translation
	// ------------------------------------------------------------
	logic df_prev_q, dclaim_q, daddr_q, dexp_q;
	logic [3:0] dev_num;
	logic [PBC_IDSEL_COUNT-1:0] idsel;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			df_prev_q <= 1'b1;
			daddr_q <= 1'b0;
			dexp_q <= 1'b0;
			dclaim_q <= 1'b0;
		end else if (up_edge) begin
			df_prev_q <= df_n;
			daddr_q <= !df_n && df_prev_q;
			dexp_q <= ^{dad, dcbe};
			if (daddr_q) begin
				dclaim_q <= down_hit_up && !down_hit_down && (dexp_q == dn_pin);
			end else if (df_n && di_n) begin
				dclaim_q <= 1'b0;
			end
		end
	end
	assign down_devsel_n = !dclaim_q;
	assign down_devsel_oe = dclaim_q;
	assign down_stop_n = !(dclaim_q && down_write && !post_room);

	assign dev_num = addr_lat_q[PBC_DEVNUM_LSB +: 4];
	// One-hot select from device number
	genvar gi;
	generate
		for (gi = 0; gi < PBC_IDSEL_COUNT; gi++) begin : g_idsel
			assign idsel[gi] = !addr_lat_q[PBC_DEVNUM_LSB + 4] && (dev_num == 4'(gi));
		end
	endgenerate

	// ------------------------------------------------------------
	// Master side on downstream bus with abort
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PBC_M_IDLE,
		PBC_M_ADDR,
		PBC_M_WAIT,
		PBC_M_DROP,
		PBC_M_REL
	} pbc_mst_t;
	pbc_mst_t mst_q;
	logic [2:0] wait_q;
	pbc_req_t req_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			req_q <= '0;
		end else if (up_edge && addr_q && claim_q == 1'b0 && up_hit_down && !up_hit_up && up_odev_n) begin
			req_q.ad <= up_cfg_type1 ? {idsel, addr_lat_q[15:2], PBC_TYPE0} : addr_lat_q;
			req_q.cbe <= cbe_lat_q;
			req_q.write <= up_write;
			req_q.cfg_type1 <= up_cfg_type1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mst_q <= PBC_M_IDLE;
			wait_q <= 3'h0;
			down_master_abort <= 1'b0;
		end else if (up_edge) begin
			down_master_abort <= 1'b0;
			unique case (mst_q)
				PBC_M_IDLE: begin
					if (claim_q && !up_stop_n) begin
						mst_q <= PBC_M_ADDR;
					end
				end
				PBC_M_ADDR: begin
					mst_q <= PBC_M_WAIT;
					wait_q <= 3'h0;
				end
				PBC_M_WAIT: begin
					wait_q <= wait_q + 3'h1;
					if (!req_q.write && !dn_tdev_n && (dexp_q != dn_pin)) begin
						mst_q <= PBC_M_DROP;
						down_master_abort <= 1'b1;
					end else if (wait_q == 3'h4 && dn_tdev_n) begin
						mst_q <= PBC_M_DROP;
						down_master_abort <= 1'b1;
					end else if (!dn_tdev_n) begin
						mst_q <= PBC_M_DROP;
					end
				end
				// Frame already released, irdy follows one clock later
				PBC_M_DROP: begin
					mst_q <= PBC_M_REL;
				end
				PBC_M_REL: begin
					mst_q <= PBC_M_IDLE;
				end
			endcase
		end
	end
	assign down_master_oe = (mst_q != PBC_M_IDLE);
	assign down_frame_out_n = !(mst_q == PBC_M_ADDR || mst_q == PBC_M_WAIT);
	assign down_irdy_out_n = !(mst_q == PBC_M_WAIT || mst_q == PBC_M_DROP);
	assign down_ad_out = req_q.ad;
	assign down_ad_oe = (mst_q == PBC_M_ADDR);

	// Downstream address parity one clock after address
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			down_parity <= 1'b0;
			down_parity_oe <= 1'b0;
		end else if (up_edge) begin
			down_parity <= ^{req_q.ad, req_q.cbe};
			down_parity_oe <= (mst_q == PBC_M_ADDR);
		end
	end

	// ------------------------------------------------------------
	// Posted write words through the two-entry buffer
	// ------------------------------------------------------------
	pbc_buf2 #(.WIDTH(36)) u_buf (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(up_edge && cyc_write_q && !ui_n && !up_trdy_n),
		.in_ready(buf_in_ready),
		.in_data({uad, ucbe}),
		.out_valid(fwd_valid),
		.out_ready(fwd_ready),
		.out_data(fwd_word)
	);
endmodule
`default_nettype wire

// [sim/pbc_bridge_sva.sv]
// Checker of the bridge error and claim outputs
`timescale 1ns/10ps
`default_nettype none
module pbc_bridge_sva
	import pbc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [15:0] cmd_rdata,
	input wire logic [15:0] pulse_rdata,
	input wire logic up_devsel_n,
	input wire logic up_devsel_oe,
	input wire logic up_system_error_n,
	input wire logic up_system_error_oe,
	input wire logic up_parity_error_oe,
	input wire logic down_frame_out_n,
	input wire logic down_irdy_out_n,
	input wire logic down_master_oe,
	input wire logic down_master_abort
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// --------------------------------------------------------------
	// Error pins
	// --------------------------------------------------------------
	a_serr_needs_enables: assert property (up_system_error_oe |-> cmd_rdata[8] && cmd_rdata[6])
		else $error("system error driven while disabled");
	a_perr_needs_enable: assert property (up_parity_error_oe |-> cmd_rdata[6])
		else $error("parity error driven while disabled");
	a_serr_drives_low: assert property (up_system_error_oe |-> !up_system_error_n)
		else $error("system error driven high");
	a_serr_one_clock: assert property ($rose(up_system_error_oe) |-> up_system_error_oe[*8] ##1 !up_system_error_oe)
		else $error("system error pulse not one bus clock");
	a_perr_one_clock: assert property ($rose(up_parity_error_oe) |-> up_parity_error_oe[*8] ##1 !up_parity_error_oe)
		else $error("parity error pulse not one bus clock");
	a_serr_no_claim: assert property (up_system_error_oe |-> up_devsel_n)
		else $error("claim during address parity error");
	// --------------------------------------------------------------
	// Claim and master pins, pulse reset bit
	// --------------------------------------------------------------
	a_devsel_is_driven: assert property (!up_devsel_n |-> up_devsel_oe)
		else $error("devsel low while not driven");
	a_frame_before_irdy: assert property ($rose(down_frame_out_n) && down_master_oe |-> !down_irdy_out_n)
		else $error("irdy released with frame");
	a_irdy_after_frame: assert property ($rose(down_irdy_out_n) && down_master_oe |-> down_frame_out_n)
		else $error("irdy released before frame");
	a_pulse_reset_hold: assert property ($rose(pulse_rdata[0]) |-> pulse_rdata[0][*8])
		else $error("pulse reset bit too short");
	// Main scenarios
	c_serr: cover property ($rose(up_system_error_oe));
	c_perr: cover property ($rose(up_parity_error_oe));
	c_claim: cover property ($fell(up_devsel_n));
	c_abort: cover property (down_master_abort);
endmodule
bind pbc_bridge pbc_bridge_sva pbc_bridge_sva_i (.*);
`default_nettype wire

// [sim/pbc_far_model.sv]
// Downstream target and forwarded-word sink
`timescale 1ns/10ps
`default_nettype none
module pbc_far_model (
	input wire logic sys_clk,
	input wire logic absent,
	input wire logic stall,
	input wire logic down_frame_out_n,
	input wire logic down_irdy_out_n,
	output logic down_target_devsel_n,
	output logic fwd_ready
);
	logic [3:0] wait_q = 4'h0;
	// Medium decode, never answers while absent; idle line sits at its pull-up
	always @(posedge sys_clk) begin
		fwd_ready <= !stall;
		if (down_frame_out_n && down_irdy_out_n) begin
			wait_q <= 4'h0;
			down_target_devsel_n <= 1'b1;
		end else if (wait_q != 4'hf) begin
			wait_q <= wait_q + 4'h1;
		end else begin
			down_target_devsel_n <= absent;
		end
	end
endmodule
`default_nettype wire

// [sim/pbc_bridge_test.sv]
// Self-checking bench of the bridge claim and parity block
`timescale 1ns/10ps
`default_nettype none
module pbc_bridge_test
	import pbc_pkg::*;
;
	logic sys_clk, rst, up_clk, up_frame_n, up_irdy_n, up_parity_in, up_other_devsel_n, up_hit_down, up_hit_up;
	logic up_write, up_cfg_type1, down_frame_n, down_irdy_n, down_parity_in, down_hit_up, down_hit_down, down_write;
	logic down_target_devsel_n, read_valid, post_room, cmd_wr, fwd_ready, fwd_valid, clr, absent, stall, par_seen;
	logic up_devsel_n, up_devsel_oe, up_stop_n, up_trdy_n, up_parity, up_parity_oe, up_system_error_n;
	logic up_system_error_oe, up_parity_error_n, up_parity_error_oe, down_devsel_n, down_devsel_oe, down_stop_n;
	logic down_parity, down_parity_oe, down_frame_out_n, down_irdy_out_n, down_master_oe, down_master_abort, down_ad_oe;
	logic [15:0] cmd_wdata, cmd_w1c, cmd_w1s, cmd_w1r, status_set, cmd_rdata, status_rdata, pulse_rdata;
	logic [31:0] up_ad_in, down_ad_in, read_data, down_ad_out, ad_seen;
	logic [3:0] up_cbe_n_in, down_cbe_n_in;
	logic [5:0] flg;
	pbc_word_t fwd_word;
	int bad_count = 0;
	int total_checks = 0;
	int nfwd = 0;
	pbc_bridge pbc_bridge_i (.*);
	pbc_far_model pbc_far_model_i (.*);
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Link clock, unrelated in phase
	initial begin
		up_clk = 1'b0;
		#7;
		forever #100 up_clk = ~up_clk;
	end
	// Sticky flags: devsel, stop, serr, perr, down devsel, abort
	always @(posedge sys_clk) begin
		flg <= clr ? 6'h00 : flg | {!up_devsel_n, !up_stop_n, up_system_error_oe, up_parity_error_oe, !down_devsel_n, down_master_abort};
		par_seen <= clr ? 1'b0 : (up_parity_oe ? up_parity : par_seen);
		if ($fell(down_frame_out_n)) ad_seen <= down_ad_out;
		if (fwd_valid && fwd_ready) nfwd <= nfwd + 1;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic bclk(input int n);
		repeat (n) begin
			@(negedge up_clk);
			@(posedge sys_clk);
		end
	endtask
	// One single-phase upstream transfer; ea, ed spoil address or data parity
	task automatic up_cyc(input logic [31:0] a, input logic [31:0] d, input logic [3:0] h, input logic ea, input logic ed);
		clr <= 1'b1;
		bclk(1);
		clr <= 1'b0;
		{up_hit_down, up_hit_up, up_write, up_cfg_type1} <= h;
		{up_frame_n, up_ad_in, up_cbe_n_in} <= {1'b0, a, 4'h7};
		bclk(1);
		up_parity_in <= ^{a, 4'h7} ^ ea;
		{up_frame_n, up_irdy_n, up_ad_in, up_cbe_n_in} <= {2'h2, d, 4'h0};
		bclk(1);
		up_parity_in <= ^d ^ ed;
		bclk(1);
		{up_irdy_n, up_ad_in, up_hit_down, up_hit_up} <= {1'b1, ~d, 2'h0};
		bclk(4);
	endtask
	task automatic cmd_write(input logic [15:0] v);
		{cmd_wr, cmd_wdata} <= {1'b1, v};
		@(posedge sys_clk);
		cmd_wr <= 1'b0;
		@(posedge sys_clk);
		@(posedge sys_clk);
		chk("command", v, cmd_rdata);
	endtask
	task automatic t_claim;
		logic [7:0] tc [5] = '{8'ha6, 8'h64, 8'h24, 8'hac, 8'ha3};
		for (int i = 0; i < 5; i++) begin
			{up_other_devsel_n, post_room} <= {!tc[i][3], tc[i][2]};
			up_cyc(32'h1000_0040, 32'h1234_5678, tc[i][7:4], 1'b0, 1'b0);
			chk("up devsel", tc[i][1], flg[5]);
			chk("up stop", tc[i][0], flg[4]);
		end
		{up_other_devsel_n, post_room} <= 2'h3;
		for (int i = 2; i >= 0; i--) begin
			clr <= 1'b1;
			bclk(1);
			clr <= 1'b0;
			{down_hit_up, down_hit_down, down_frame_n, down_ad_in} <= {i[1:0], 1'b0, 32'h8000_0040};
			bclk(1);
			{down_parity_in, down_frame_n, down_irdy_n} <= 3'h2;
			bclk(4);
			{down_irdy_n, down_ad_in, down_hit_up, down_hit_down} <= {1'b1, 32'h7fff_ffbf, 2'h0};
			bclk(4);
			chk("down devsel", i == 2, flg[1]);
		end
		$display("claim tests done");
	endtask
	task automatic t_parity;
		cmd_write(16'h0140);
		up_cyc(32'h2000_0000, 32'h0000_00ff, 4'ha, 1'b1, 1'b0);
		chk("serr", 1, flg[3]);
		chk("devsel on bad address", 0, flg[5]);
		up_cyc(32'h2000_0000, 32'h0000_00ff, 4'ha, 1'b0, 1'b1);
		chk("perr", 1, flg[2]);
		cmd_write(16'h0040);
		up_cyc(32'h2000_0000, 32'h0000_00ff, 4'ha, 1'b1, 1'b0);
		chk("serr disabled", 0, flg[3]);
		cmd_write(16'h0000);
		up_cyc(32'h2000_0000, 32'h0000_00ff, 4'ha, 1'b0, 1'b1);
		chk("perr disabled", 0, flg[2]);
		{read_data, read_valid} <= {32'h0000_0f01, 1'b1};
		repeat (2) up_cyc(32'h3000_0000, 32'h0, 4'h8, 1'b0, 1'b0);
		chk("read parity", 1, par_seen);
		read_valid <= 1'b0;
		for (int e = 0; e < 2; e++) begin
			down_parity_in <= e[0];
			up_cyc(32'h3000_0000, 32'h0, 4'h8, 1'b0, 1'b0);
			bclk(8);
			chk("read master abort", e[0], flg[0]);
		end
		down_parity_in <= 1'b0;
		$display("parity tests done");
	endtask
	task automatic t_config;
		logic [4:0] dv [4] = '{5'h00, 5'h05, 5'h0f, 5'h10};
		for (int i = 0; i < 4; i++) begin
			{absent, post_room} <= {dv[i] >= 5'h0f, 1'b0};
			up_cyc({16'h0, dv[i], 11'h001}, 32'h0, 4'hb, 1'b0, 1'b0);
			bclk(8);
			chk("idsel", dv[i] < 5'h10 ? 16'h0001 << dv[i] : 16'h0, ad_seen[31:16]);
			chk("config type", PBC_TYPE0, ad_seen[1:0]);
			chk("master abort", dv[i] >= 5'h0f, flg[0]);
		end
		{absent, stall, post_room} <= 3'h3;
		bclk(4);
		begin
			int n0 = nfwd;
			repeat (2) up_cyc(32'h1000_0080, 32'h5a5a_0001, 4'ha, 1'b0, 1'b0);
			chk("words while stalled", n0, nfwd);
			stall <= 1'b0;
			bclk(4);
			chk("words drained", n0 + 2, nfwd);
		end
		{cmd_w1r} <= 16'h0001;
		@(posedge sys_clk);
		cmd_w1r <= 16'h0000;
		repeat (2) @(posedge sys_clk);
		chk("pulse reset on", 1, pulse_rdata[0]);
		repeat (PBC_PULSE_RESET_CLOCKS + 2) @(posedge sys_clk);
		chk("pulse reset off", 0, pulse_rdata[0]);
		status_set <= 16'h0005;
		@(posedge sys_clk);
		{status_set, cmd_w1c} <= {16'h0001, 16'h0005};
		@(posedge sys_clk);
		{status_set, cmd_w1c} <= 32'h0000_0000;
		repeat (2) @(posedge sys_clk);
		chk("status set wins", 16'h0001, status_rdata);
		$display("config and register tests done");
	endtask
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#300000;
		bad_count++;
		stop_test();
	end
	initial begin
		{rst, clr, absent, stall, cmd_wr, read_valid, post_room, up_other_devsel_n} = 8'h83;
		{up_frame_n, up_irdy_n, up_parity_in, up_hit_down, up_hit_up, up_write, up_cfg_type1} = 7'h60;
		{down_frame_n, down_irdy_n, down_parity_in, down_hit_up, down_hit_down, down_write} = 6'h31;
		{up_ad_in, up_cbe_n_in, down_ad_in, down_cbe_n_in, read_data} = '0;
		{cmd_wdata, cmd_w1c, cmd_w1s, cmd_w1r, status_set} = '0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("command reset", PBC_CMD_RESET, cmd_rdata);
		t_claim();
		t_parity();
		t_config();
		stop_test();
	end
endmodule
`default_nettype wire
